// *** logic/pptst_params.svh ***
`ifndef PPTST_PARAMS_SVH
`define PPTST_PARAMS_SVH

`define PPTST_MAX_N        23
`define PPTST_SEED         23'h7fffff
`define PPTST_LEN_9        5'h09
`define PPTST_LEN_11       5'h0b
`define PPTST_LEN_15       5'h0f
`define PPTST_LEN_23       5'h17
`define PPTST_TAP_9        5'h05
`define PPTST_TAP_11       5'h09
`define PPTST_TAP_15       5'h0e
`define PPTST_TAP_23       5'h12
`define PPTST_INTEG_MS     1000
`define PPTST_CLK_KHZ      20000
`define PPTST_INTEG_CYCLES (`PPTST_INTEG_MS * `PPTST_CLK_KHZ)
`define PPTST_BER_NUM      40'h1
`define PPTST_BER_DEN      40'h5
`define PPTST_VERIFY_LEN   8'h20
`define PPTST_OOP_LEN      8'h20

`endif

// *** logic/pptst_pkg.sv ***
package pptst_pkg;
  `include "pptst_params.svh"

  typedef enum logic [1:0] {
    PPTST_SEQ_9  = 2'b00,
    PPTST_SEQ_11 = 2'b01,
    PPTST_SEQ_15 = 2'b10,
    PPTST_SEQ_23 = 2'b11
  } pptst_seq_e;

  typedef enum logic [1:0] {
    PPTST_CHK_HUNT   = 2'b00,
    PPTST_CHK_VERIFY = 2'b01,
    PPTST_CHK_SYNC   = 2'b10
  } pptst_chk_e;

  typedef logic [`PPTST_MAX_N-1:0] pptst_sr_t;

  typedef struct packed {
    pptst_sr_t sr;
  } pptst_gen_s;

  typedef struct packed {
    pptst_chk_e  state;
    pptst_sr_t   ref_sr;
    pptst_sr_t   hist;
    logic [7:0]  cnt;
    logic [7:0]  oop_cnt;
    logic [31:0] win_cyc;
    logic [31:0] win_bits;
    logic [31:0] win_errs;
    logic [31:0] err_total;
    logic        sync;
    logic        err_pulse;
    logic        loss;
    logic        tx_data;
    logic        tx_valid;
  } pptst_top_s;

  function automatic logic [4:0] pptst_len(pptst_seq_e s);
    case (s)
      PPTST_SEQ_9:  return `PPTST_LEN_9;
      PPTST_SEQ_11: return `PPTST_LEN_11;
      PPTST_SEQ_15: return `PPTST_LEN_15;
      default:      return `PPTST_LEN_23;
    endcase
  endfunction

  function automatic logic [4:0] pptst_tap(pptst_seq_e s);
    case (s)
      PPTST_SEQ_9:  return `PPTST_TAP_9;
      PPTST_SEQ_11: return `PPTST_TAP_11;
      PPTST_SEQ_15: return `PPTST_TAP_15;
      default:      return `PPTST_TAP_23;
    endcase
  endfunction

  // Long sequences are sent inverted by default
  function automatic logic pptst_def_inv(pptst_seq_e s);
    return (s == PPTST_SEQ_15) || (s == PPTST_SEQ_23);
  endfunction

  function automatic logic pptst_fb(pptst_sr_t q, pptst_seq_e s);
    return q[pptst_tap(s) - 5'h01] ^ q[pptst_len(s) - 5'h01];
  endfunction

  function automatic pptst_sr_t pptst_mask(pptst_seq_e s);
    pptst_sr_t m;
    m = '0;
    for (int i = 0; i < `PPTST_MAX_N; i++) begin
      m[i] = (5'(i) < pptst_len(s));
    end
    return m;
  endfunction
endpackage

// *** logic/pptst_gen_if.sv ***
`timescale 1ns/1ns
interface pptst_gen_if;
  import pptst_pkg::*;
  pptst_seq_e seq_sel;
  logic       advance;
  logic       seq_bit;

  modport gen (input seq_sel, input advance, output seq_bit);
  modport ctl (output seq_sel, output advance, input seq_bit);
endinterface

// *** logic/pptst_gen.sv ***
`timescale 1ns/1ns
`include "pptst_params.svh"
module pptst_gen
  import pptst_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  pptst_gen_if.gen  gen_if
);
  pptst_gen_s st_reg;
  pptst_gen_s st_next;

  always_comb begin
    st_next = st_reg;
    if (gen_if.advance) begin
      st_next.sr = {st_reg.sr[`PPTST_MAX_N-2:0], pptst_fb(st_reg.sr, gen_if.seq_sel)};
    end
    // Lockup guard: all-zero register would stick forever
    if ((st_next.sr & pptst_mask(gen_if.seq_sel)) == '0) begin
      st_next.sr = `PPTST_SEED;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      st_reg.sr <= `PPTST_SEED;
    end else begin
      st_reg <= st_next;
    end
  end

  // Plain stage-n output, zero runs stay at n - 1
  assign gen_if.seq_bit = st_reg.sr[pptst_len(gen_if.seq_sel) - 5'h01];
endmodule

// *** logic/pptst_top.sv ***
`timescale 1ns/1ns
`include "pptst_params.svh"
// Functional notes
// - Maximal-length LFSR, period two-power-n minus one
// - Plain output: longest zero run n-1
// - Invert option complements every output bit
// - Compare each bit; count only when synchronized
// - Loss when error ratio >= 0.20 per second
// - Loss when out of phase is detected
// - On loss, restart resynchronization immediately
// - Out-of-phase: error pattern follows sequence structure
// - Framed mode: hold sequence during alignment bits
// - Sequence length selectable per bit rate
// - 15 stages: taps 14,15, inverted output
// - 23 stages: taps 18,23, inverted output
// - 9 stages: taps 5,9, start at ones
// - 11 stages: taps 9,11, plain output
module pptst_top
  import pptst_pkg::*;
#(
  parameter logic [31:0] INTEG_CYCLES = 32'(`PPTST_INTEG_CYCLES),
  parameter logic [7:0]  VERIFY_LEN   = `PPTST_VERIFY_LEN,
  parameter logic [7:0]  OOP_LEN      = `PPTST_OOP_LEN
) (
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [1:0]  seq_sel_i,
  input  wire logic        invert_i,
  input  wire logic        framed_i,
  input  wire logic        fas_slot_i,
  input  wire logic        bit_en_i,
  output logic             tx_data_o,
  output logic             tx_valid_o,
  input  wire logic        rx_data_i,
  input  wire logic        rx_valid_i,
  output logic             sync_o,
  output logic             err_pulse_o,
  output logic             loss_o,
  output logic [31:0]      err_count_o
);
  // ----------------------------------------
  // Generator
  // ----------------------------------------
  pptst_gen_if gen_if ();
  pptst_seq_e  seq_sel;
  logic        inv;
  logic        tx_step;

  assign seq_sel = pptst_seq_e'(seq_sel_i);
  // Pin can only add inversion; long sequences always leave inverted
  assign inv     = invert_i | pptst_def_inv(seq_sel);
  assign tx_step = bit_en_i & ~(framed_i & fas_slot_i);

  assign gen_if.seq_sel = seq_sel;
  assign gen_if.advance = tx_step;

  // Generator holds in framed-mode alignment slots and idle bit slots
  pptst_gen u_gen (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .gen_if    (gen_if)
  );

  // ----------------------------------------
  // Checker and output state
  // ----------------------------------------
  pptst_top_s st_reg;
  pptst_top_s st_next;

  always_comb begin
    logic        d;
    logic        exp_bit;
    logic        e;
    logic        conform;
    logic        oop;
    logic        ber_loss;
    logic        win_end;
    logic        dead_ref;
    logic [39:0] lhs;
    logic [39:0] rhs;
    d        = 1'b0;
    exp_bit  = 1'b0;
    e        = 1'b0;
    conform  = 1'b0;
    oop      = 1'b0;
    ber_loss = 1'b0;
    win_end  = 1'b0;
    lhs      = '0;
    rhs      = '0;
    dead_ref = 1'b0;

    st_next  = st_reg;
    // Event outputs last one cycle
    st_next.err_pulse = 1'b0;
    st_next.loss      = 1'b0;

    // ----------------------------------------
    // Transmit latch
    // ----------------------------------------
    // Bit latched in the cycle the generator steps
    st_next.tx_valid = tx_step;
    if (tx_step) begin
      st_next.tx_data = gen_if.seq_bit ^ inv;
    end

    // ----------------------------------------
    // Receive checker
    // ----------------------------------------
    d       = rx_data_i ^ inv;
    exp_bit = pptst_fb(st_reg.ref_sr, seq_sel);
    // Stuck line seeds an all-zero reference that predicts itself
    dead_ref = ((st_reg.ref_sr & pptst_mask(seq_sel)) == '0);

    case (st_reg.state)
      // Fill the reference with raw received bits
      PPTST_CHK_HUNT: begin
        st_next.sync = 1'b0;
        if (rx_valid_i) begin
          st_next.ref_sr = {st_reg.ref_sr[`PPTST_MAX_N-2:0], d};
          st_next.cnt    = st_reg.cnt + 8'h01;
          if (st_reg.cnt + 8'h01 >= {3'h0, pptst_len(seq_sel)}) begin
            st_next.state = PPTST_CHK_VERIFY;
            st_next.cnt   = '0;
          end
        end
      end

      // Predicted bits must all match before lock
      PPTST_CHK_VERIFY: begin
        if (rx_valid_i) begin
          st_next.ref_sr = {st_reg.ref_sr[`PPTST_MAX_N-2:0], d};
          if ((d != exp_bit) || dead_ref) begin
            // Any miss or a dead seed means the seed is unusable
            st_next.state = PPTST_CHK_HUNT;
            st_next.cnt   = '0;
          end else if (st_reg.cnt + 8'h01 >= VERIFY_LEN) begin
            // Fresh window and error history on every new lock
            st_next.state     = PPTST_CHK_SYNC;
            st_next.sync      = 1'b1;
            st_next.cnt       = '0;
            st_next.hist      = '0;
            st_next.oop_cnt   = '0;
            st_next.win_cyc   = '0;
            st_next.win_bits  = '0;
            st_next.win_errs  = '0;
          end else begin
            st_next.cnt = st_reg.cnt + 8'h01;
          end
        end
      end

      // Flywheel, count errors, watch both loss causes
      PPTST_CHK_SYNC: begin
        st_next.win_cyc = st_reg.win_cyc + 32'h1;
        if (rx_valid_i) begin
          // Flywheel on the prediction so errors do not corrupt the reference
          st_next.ref_sr   = {st_reg.ref_sr[`PPTST_MAX_N-2:0], exp_bit};
          e                = d ^ exp_bit;
          st_next.hist     = {st_reg.hist[`PPTST_MAX_N-2:0], e};
          st_next.win_bits = st_reg.win_bits + 32'h1;
          if (e) begin
            st_next.win_errs  = st_reg.win_errs + 32'h1;
            st_next.err_total = st_reg.err_total + 32'h1;
            st_next.err_pulse = 1'b1;
          end
          // Shifted copy of the sequence leaves errors obeying the recursion
          conform = (e == pptst_fb(st_reg.hist, seq_sel)) &&
                    ((st_reg.hist & pptst_mask(seq_sel)) != '0);
          st_next.oop_cnt = conform ? st_reg.oop_cnt + 8'h01 : 8'h00;
          oop             = conform && (st_reg.oop_cnt + 8'h01 >= OOP_LEN);
        end

        // Ratio test without a divider: errors * den >= bits * num
        win_end = (st_reg.win_cyc >= INTEG_CYCLES - 32'h1);
        if (win_end) begin
          lhs      = 40'(st_next.win_errs) * `PPTST_BER_DEN;
          rhs      = 40'(st_next.win_bits) * `PPTST_BER_NUM;
          ber_loss = (st_next.win_bits != '0) && (lhs >= rhs);
          st_next.win_cyc  = '0;
          st_next.win_bits = '0;
          st_next.win_errs = '0;
        end

        // Either cause drops lock and restarts hunting at once
        if (oop || ber_loss) begin
          st_next.loss  = 1'b1;
          st_next.sync  = 1'b0;
          st_next.state = PPTST_CHK_HUNT;
          st_next.cnt   = '0;
        end
      end

      // Unused code falls back to hunting
      default: begin
        st_next.state = PPTST_CHK_HUNT;
        st_next.sync  = 1'b0;
        st_next.cnt   = '0;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      st_reg <= '{state: PPTST_CHK_HUNT, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign tx_data_o   = st_reg.tx_data;
  assign tx_valid_o  = st_reg.tx_valid;
  assign sync_o      = st_reg.sync;
  assign err_pulse_o = st_reg.err_pulse;
  assign loss_o      = st_reg.loss;
  assign err_count_o = st_reg.err_total;
endmodule

// *** dv/pptst_top_monitor.sv ***
`timescale 1ns/1ns
module pptst_top_monitor (
  input wire logic        sys_clk_i,
  input wire logic        resetn_i,
  input wire logic        framed_i,
  input wire logic        fas_slot_i,
  input wire logic        bit_en_i,
  input wire logic        tx_data_o,
  input wire logic        tx_valid_o,
  input wire logic        rx_valid_i,
  input wire logic        sync_o,
  input wire logic        err_pulse_o,
  input wire logic        loss_o,
  input wire logic [31:0] err_count_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_take; bit_en_i && !(framed_i && fas_slot_i); endsequence
  sequence s_hold; bit_en_i && framed_i && fas_slot_i; endsequence
  chk_tx_taken: assert property (s_take |=> tx_valid_o) else $error("bit not sent");
  chk_fas_hold: assert property (s_hold |=> !tx_valid_o) else $error("sent in alignment");
  chk_tx_idle: assert property (!bit_en_i |=> !tx_valid_o) else $error("spurious bit");
  chk_data_stands: assert property ($past(resetn_i) && !tx_valid_o |-> $stable(tx_data_o)) else $error("data moved");
  chk_err_synced: assert property (err_pulse_o |-> $past(sync_o) && $past(rx_valid_i)) else $error("error unsynced");
  chk_err_count: assert property ($past(resetn_i) |-> err_count_o == $past(err_count_o) + 32'(err_pulse_o))
    else $error("count off");
  chk_loss_drop: assert property (loss_o |-> !sync_o && $past(sync_o)) else $error("loss not from sync");
  chk_loss_hunt: assert property (loss_o |=> (!sync_o && !loss_o) [*8]) else $error("no resync");
  chk_sync_rise: assert property ($rose(sync_o) |-> $past(rx_valid_i) && !err_pulse_o) else $error("bad sync");
  chk_sync_fall: assert property ($past(resetn_i) && $fell(sync_o) |-> loss_o) else $error("silent fall");
endmodule
bind pptst_top pptst_top_monitor mon_u (.*);

// *** dv/pptst_eut_model.sv ***
`timescale 1ns/1ns
module pptst_eut_model (
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  input  wire logic tx_data_i,
  input  wire logic tx_valid_i,
  input  wire logic flip_i,
  input  wire logic drop_i,
  output logic      rx_data_o,
  output logic      rx_valid_o
);
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rx_valid_o <= 1'h0;
      rx_data_o  <= 1'h0;
    end else begin
      rx_valid_o <= tx_valid_i && !drop_i;
      // Junk between bits, so a stale bit never passes
      rx_data_o  <= tx_valid_i ? tx_data_i ^ flip_i : ~rx_data_o;
    end
  end
endmodule

// *** dv/prbs_pattern_tester_tb.sv ***
`timescale 1ns/1ns
module prbs_pattern_tester_tb;
  typedef struct {logic [1:0] sel; logic inv; int n; int tap; logic xinv; int zrun;} pptst_row_s;
  pptst_row_s  rows[6] = '{'{2'h0, 1'h0, 9, 5, 1'h0, 8}, '{2'h0, 1'h1, 9, 5, 1'h1, 9}, '{2'h1, 1'h0, 11, 9, 1'h0, -1},
    '{2'h1, 1'h1, 11, 9, 1'h1, -1}, '{2'h2, 1'h0, 15, 14, 1'h1, -1}, '{2'h3, 1'h0, 23, 18, 1'h1, -1}};
  logic        sys_clk_i = 1'h0;
  logic        resetn_i, invert_i, framed_i, fas_slot_i, bit_en_i, flip_en, drop_en, seen, b;
  logic        tx_data_o, tx_valid_o, rx_data_i, rx_valid_i, sync_o, err_pulse_o, loss_o;
  logic [1:0]  seq_sel_i;
  logic [31:0] err_count_o;
  logic [22:0] q;
  int          fail_count, check_count, run, zmax;
  int          cyc_count = 0;

  pptst_top #(.INTEG_CYCLES(32'h0000_00c8)) dut_u (.*);
  pptst_eut_model eut_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
    .flip_i(flip_en), .drop_i(drop_en), .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i));

  always #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      fail_count++;
      $display("wrong value at %0t: got %h, want %h", $time, got, want);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic do_reset(input logic [1:0] sel, input logic inv);
    resetn_i = 1'h0;
    seq_sel_i = sel;
    invert_i = inv;
    {framed_i, fas_slot_i, bit_en_i, flip_en, drop_en} = '0;
    tick(8);
    check(err_count_o, 32'h0);
    check(32'({tx_valid_o, sync_o, err_pulse_o, loss_o}), 32'h0);
    resetn_i = 1'h1;
  endtask

  task automatic wait_sync(input int lim);
    for (int i = 0; i < lim && sync_o !== 1'h1; i++) tick(1);
  endtask

  // Flip every p-th bit until loss or limit; p of zero flips nothing
  task automatic burst(input int p, input int lim);
    seen = 1'h0;
    for (int k = 0; k < lim && !seen; k++) begin
      flip_en = (p != 0) && (k % p == 0);
      tick(1);
      seen = (loss_o === 1'h1);
    end
    flip_en = 1'h0;
  endtask

  initial begin
    fail_count = 0;
    check_count = 0;
    for (int r = 0; r < 6; r++) begin
      do_reset(rows[r].sel, rows[r].inv);
      {framed_i, bit_en_i} = 2'h3;
      q = '1;
      run = 0;
      zmax = 0;
      for (int k = 0; k < 700; k++) begin
        fas_slot_i = (k % 8 == 7);
        bit_en_i = (k % 8 != 3);
        tick(1);
        check(32'(tx_valid_o), 32'(bit_en_i && !fas_slot_i));
        if (bit_en_i && !fas_slot_i) begin
          b = q[rows[r].n-1] ^ rows[r].xinv;
          check(32'(tx_data_o), 32'(b));
          run = b ? 0 : run + 1;
          zmax = (run > zmax) ? run : zmax;
          q = {q[21:0], q[rows[r].tap-1] ^ q[rows[r].n-1]};
        end
      end
      if (rows[r].zrun >= 0) check(zmax, rows[r].zrun);
      check(32'(sync_o), 32'h1);
      check(err_count_o, 32'h0);
    end
    do_reset(2'h0, 1'h0);
    {bit_en_i, fas_slot_i} = 2'h3;
    wait_sync(100);
    check(32'(sync_o), 32'h1);
    check(32'(tx_valid_o), 32'h1);
    burst(1, 1);
    tick(1);
    check(32'(err_pulse_o), 32'h1);
    check(err_count_o, 32'h1);
    burst(6, 500);
    check(32'(seen), 32'h0);
    tick(3);
    check(err_count_o, 32'h55);
    burst(5, 450);
    check(32'(seen), 32'h1);
    check(32'(sync_o), 32'h0);
    wait_sync(100);
    check(32'(sync_o), 32'h1);
    drop_en = 1'h1;
    tick(1);
    drop_en = 1'h0;
    burst(0, 200);
    check(32'(seen), 32'h1);
    wait_sync(100);
    check(32'(sync_o), 32'h1);
    do_reset(2'h0, 1'h0);
    complete_run();
  end
endmodule
